// ===== hw/ricg_dev.sv
// Device end: identity code, identity stage, gated memory stage.
// Assumes the master keeps slots at least four clocks apart.
// How it works
// R1 - Identity is family, serial, check byte
// R2 - Check byte covers first 56 identity bits
// R3 - Polynomial has terms eight, five, four, zero
// R4 - Accumulator starts cleared to zero
// R5 - Family LSB first, then serial, one bit
// R6 - Shifting check byte too leaves zero
// R7 - Memory commands locked until identity stage done
// R8 - Master opens with read, match, search, skip
// R9 - Five memory commands after identity stage
// R10 - Every byte travels LSB first
// R11 - Programming only clears ones to zeros
// R12 - Programming voltage raises flag, qualifies programming
// R13 - Identity commands select and enumerate devices
// R14 - Command, then address low, then high
// R15 - Right shift, XOR taps when feedback one
`timescale 1ns/1ps
module ricg_dev #(
	parameter logic [7:0]  FAMILY = 8'h5a,          // Arbitrary value
	parameter logic [47:0] SERIAL = 48'h1234_5678_9abc // Arbitrary value
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       srst,
	// Link
	ricg_if.dev                             link,
	// User side
	output logic                            unlocked,
	output logic                            prog_flag,
	output logic [ricg_pkg::ID_BITS-1:0]    id_code
);
	import ricg_pkg::*;
	typedef enum logic [3:0] {
		ST_ID_CMD, ST_READ_ID, ST_MATCH, ST_SEARCH, ST_MEM_CMD,
		ST_ADDR, ST_TX_CRC, ST_RD_DATA, ST_RD_CRC, ST_WR_DATA,
		ST_WR_CRC, ST_PROG, ST_WR_VER, ST_IDLE
	} ricg_dst_t;
	localparam logic [ID_BITS-1:0] ID_CODE =
		{ricg_crc_body({SERIAL, FAMILY}), SERIAL, FAMILY}; // see R1, R2
	ricg_dst_t    st_reg;
	logic [7:0]   sh_reg;
	logic [2:0]   cnt_reg;
	logic [5:0]   idx_reg;
	logic [1:0]   sp_reg;
	logic [15:0]  addr_reg;
	logic [7:0]   cmd_reg;
	logic [7:0]   wdata_reg;
	logic [7:0]   crc_reg;
	logic         unl_reg;
	logic         pv_reg;
	logic         pres_reg;
	logic         tx_reg;
	logic [7:0]   data_mem [DATA_BYTES];
	logic [7:0]   stat_mem [STAT_BYTES];
	logic         bit_in;
	logic [7:0]   byte_in;
	logic         byte_done;
	logic [7:0]   crc_next;
	logic         id_bit;
	logic         is_stat;
	logic         is_write;
	logic         at_end;
	logic         wp_ok;
	logic         prog_fire;
	logic [15:0]  addr_inc;
	logic         tx_next;
	function automatic logic [7:0] rd_byte(input logic stat,
		input logic [15:0] a);
		return stat ? stat_mem[a[STAT_AW-1:0]] : data_mem[a[DATA_AW-1:0]];
	endfunction
	function automatic logic mem_cmd_ok(input logic [7:0] c);
		return c == CMD_READ_MEM || c == CMD_READ_CRC ||
			c == CMD_READ_STAT || c == CMD_WRITE_MEM ||
			c == CMD_WRITE_STAT; // see R9
	endfunction
	assign bit_in    = link.line;
	assign byte_in   = {bit_in, sh_reg[7:1]}; // see R10
	assign byte_done = link.slot && cnt_reg == 3'd7;
	assign crc_next  = ricg_crc_bit(crc_reg, bit_in); // see R3, R15
	assign id_bit    = ID_CODE[idx_reg]; // see R5, R13
	assign is_stat   = cmd_reg == CMD_READ_STAT || cmd_reg == CMD_WRITE_STAT;
	assign is_write  = cmd_reg == CMD_WRITE_MEM || cmd_reg == CMD_WRITE_STAT;
	assign addr_inc  = addr_reg + 16'd1;
	assign at_end    = is_stat ? &addr_reg[STAT_AW-1:0]
		: &addr_reg[DATA_AW-1:0];
	// Status area itself is never write protected
	assign wp_ok     = is_stat ||
		stat_mem[WP_BYTE][addr_reg[DATA_AW-1:PAGE_LSB]];
	assign prog_fire = st_reg == ST_PROG && pv_reg; // see R12
	assign unlocked  = unl_reg;
	assign prog_flag = pv_reg;
	assign id_code   = ID_CODE;
	assign link.d_bit    = tx_reg;
	assign link.presence = pres_reg;
	// Bus reset throws the device back to the identity stage
	always_ff @(posedge clk) begin
		if (srst || link.bus_reset) begin
			st_reg    <= ST_ID_CMD; // see R8
			sh_reg    <= 8'h00;
			cnt_reg   <= 3'd0;
			idx_reg   <= 6'd0;
			sp_reg    <= 2'd0;
			addr_reg  <= 16'h0000;
			cmd_reg   <= 8'h00;
			wdata_reg <= ERASED;
			crc_reg   <= CRC_INIT; // see R4
			unl_reg   <= 1'b0; // see R7
		end else begin
			if (link.slot && st_reg != ST_PROG) begin
				sh_reg  <= byte_in;
				cnt_reg <= cnt_reg + 3'd1;
				crc_reg <= crc_next; // see R6
			end
			unique case (st_reg)
				ST_ID_CMD: begin
					if (byte_done) begin
						idx_reg <= 6'd0;
						sp_reg  <= 2'd0;
						unique case (byte_in)
							CMD_READ_ID:   st_reg <= ST_READ_ID;
							CMD_MATCH_ID:  st_reg <= ST_MATCH;
							CMD_SEARCH_ID: st_reg <= ST_SEARCH;
							CMD_SKIP_ID: begin
								st_reg  <= ST_MEM_CMD;
								unl_reg <= 1'b1; // see R7
								crc_reg <= CRC_INIT;
							end
							default:       st_reg <= ST_IDLE;
						endcase
					end
				end
				ST_READ_ID, ST_MATCH: begin
					if (link.slot) begin
						idx_reg <= idx_reg + 6'd1;
						if (st_reg == ST_MATCH && bit_in != id_bit) begin
							st_reg <= ST_IDLE; // see R13
						end else if (&idx_reg) begin
							st_reg  <= ST_MEM_CMD;
							unl_reg <= 1'b1; // see R7
							crc_reg <= CRC_INIT;
						end
					end
				end
				ST_SEARCH: begin
					// Bit, complement, then the master's chosen branch
					if (link.slot) begin
						sp_reg <= sp_reg == 2'd2 ? 2'd0 : sp_reg + 2'd1;
						if (sp_reg == 2'd2) begin
							idx_reg <= idx_reg + 6'd1;
							if (bit_in != id_bit) begin
								st_reg <= ST_IDLE; // see R13
							end else if (&idx_reg) begin
								st_reg  <= ST_MEM_CMD;
								unl_reg <= 1'b1; // see R7
								crc_reg <= CRC_INIT;
							end
						end
					end
				end
				ST_MEM_CMD: begin
					if (byte_done) begin
						cmd_reg <= byte_in;
						st_reg  <= unl_reg && mem_cmd_ok(byte_in)
							? ST_ADDR : ST_IDLE; // see R7, R9
					end
				end
				ST_ADDR: begin
					if (byte_done) begin
						sp_reg <= ~sp_reg[0] ? 2'd1 : 2'd0;
						if (!sp_reg[0]) begin
							addr_reg[7:0] <= byte_in; // see R14
						end else begin
							addr_reg[15:8] <= byte_in;
							st_reg <= is_write ? ST_WR_DATA : ST_TX_CRC;
							sh_reg <= crc_next;
						end
					end
				end
				ST_TX_CRC: begin
					if (byte_done) begin
						sh_reg  <= rd_byte(is_stat, addr_reg);
						crc_reg <= CRC_INIT;
						st_reg  <= ST_RD_DATA;
					end
				end
				ST_RD_DATA: begin
					if (byte_done) begin
						if (at_end) begin
							sh_reg <= crc_next;
							st_reg <= ST_RD_CRC;
						end else begin
							addr_reg <= addr_inc;
							sh_reg   <= rd_byte(is_stat, addr_inc);
						end
					end
				end
				ST_RD_CRC, ST_WR_CRC: begin
					if (byte_done) begin
						st_reg <= st_reg == ST_WR_CRC ? ST_PROG : ST_IDLE;
					end
				end
				ST_WR_DATA: begin
					if (byte_done) begin
						wdata_reg <= byte_in;
						sh_reg    <= crc_next;
						st_reg    <= ST_WR_CRC;
					end
				end
				ST_PROG: begin
					// Verify byte shows what the cells now hold
					if (prog_fire) begin
						sh_reg <= rd_byte(is_stat, addr_reg) &
							(wp_ok ? wdata_reg : ERASED); // see R11
						st_reg <= ST_WR_VER;
					end
				end
				ST_WR_VER: begin
					if (byte_done) begin
						if (at_end) begin
							st_reg <= ST_IDLE;
						end else begin
							addr_reg <= addr_inc;
							crc_reg  <= ricg_crc_byte(ricg_crc_byte(CRC_INIT,
								addr_inc[7:0]), addr_inc[15:8]);
							st_reg   <= ST_WR_DATA;
						end
					end
				end
				ST_IDLE: ;
			endcase
		end
	end

	// Cells start erased; programming can only pull ones low
	always_ff @(posedge clk) begin
		if (srst) begin
			data_mem <= '{default: ERASED};
			stat_mem <= '{default: ERASED};
		end else if (prog_fire && wp_ok && is_stat) begin
			stat_mem[addr_reg[STAT_AW-1:0]] <=
				stat_mem[addr_reg[STAT_AW-1:0]] & wdata_reg; // see R11
		end else if (prog_fire && wp_ok) begin
			data_mem[addr_reg[DATA_AW-1:0]] <=
				data_mem[addr_reg[DATA_AW-1:0]] & wdata_reg; // see R11
		end
	end

	// Only the talking states may pull the line low
	always_comb begin
		tx_next = 1'b1;
		unique case (st_reg)
			ST_READ_ID: tx_next = id_bit; // see R5
			ST_SEARCH:  tx_next = sp_reg[1] ? 1'b1 : id_bit ^ sp_reg[0];
			ST_TX_CRC, ST_RD_DATA, ST_RD_CRC, ST_WR_CRC, ST_WR_VER:
				tx_next = sh_reg[0]; // see R10
			default: tx_next = 1'b1;
		endcase
	end

	// Link outputs and flag; presence answers every bus reset
	always_ff @(posedge clk) begin
		if (srst) begin
			pv_reg   <= 1'b0;
			pres_reg <= 1'b0;
			tx_reg   <= 1'b1;
		end else begin
			pv_reg   <= link.prog_v; // see R12
			pres_reg <= link.bus_reset;
			tx_reg   <= tx_next;
		end
	end
endmodule // ricg_dev

// ===== hw/ricg_host.sv
// Master end: bus reset, byte and bit slots, programming pulse, and a
// running check-value accumulator. Assumes the device end shares clk.
`timescale 1ns/1ps
module ricg_host #(
	parameter int SLOT_CYC  = ricg_pkg::SLOT_CYC,
	parameter int RESET_CYC = ricg_pkg::RESET_CYC,
	parameter int PROG_CYC  = ricg_pkg::PROG_CYC
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                srst,
	// Link
	ricg_if.host                     link,
	// Command port
	input  wire logic                cmd_valid,
	output logic                     cmd_ready,
	input  wire ricg_pkg::ricg_op_t  cmd_op,
	input  wire logic [7:0]          cmd_data,
	// Answer port
	output logic                     rsp_valid,
	output logic [7:0]               rsp_data,
	output logic                     presence,
	// Check value
	input  wire logic                crc_clear,
	output logic [7:0]               crc_value,
	output logic                     crc_ok
);
	import ricg_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_RESET, H_BITS, H_PROG} ricg_hst_t;

	ricg_hst_t    st_reg;
	logic [15:0]  tmr_reg;
	logic [7:0]   sh_reg;
	logic [3:0]   nb_reg;
	logic         one_reg;
	logic         brst_reg;
	logic         slot_reg;
	logic         mbit_reg;
	logic         pv_reg;
	logic         rv_reg;
	logic [7:0]   rd_reg;
	logic         pres_reg;
	logic [7:0]   crc_reg;
	logic         take;

	assign cmd_ready = st_reg == H_IDLE;
	assign take      = cmd_valid && cmd_ready;
	assign link.bus_reset = brst_reg;
	assign link.slot      = slot_reg;
	assign link.m_bit     = mbit_reg;
	assign link.prog_v    = pv_reg;
	assign rsp_valid = rv_reg;
	assign rsp_data  = rd_reg;
	assign presence  = pres_reg;
	assign crc_value = crc_reg;
	assign crc_ok    = crc_reg == CRC_INIT;

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg   <= H_IDLE;
			tmr_reg  <= 16'h0000;
			sh_reg   <= 8'hff;
			nb_reg   <= 4'd0;
			one_reg  <= 1'b0;
			brst_reg <= 1'b0;
			slot_reg <= 1'b0;
			mbit_reg <= 1'b1;
			pv_reg   <= 1'b0;
			rv_reg   <= 1'b0;
			rd_reg   <= 8'h00;
			pres_reg <= 1'b0;
		end else begin
			rv_reg   <= 1'b0;
			brst_reg <= 1'b0;
			slot_reg <= 1'b0;
			unique case (st_reg)
				H_IDLE: begin
					tmr_reg <= 16'h0000;
					if (take) begin
						unique case (cmd_op)
							OP_RESET: begin
								st_reg   <= H_RESET;
								brst_reg <= 1'b1;
								pres_reg <= 1'b0;
							end
							OP_WRITE, OP_READ: begin
								st_reg   <= H_BITS;
								sh_reg   <= cmd_op == OP_WRITE ? cmd_data : 8'hff;
								mbit_reg <= cmd_op == OP_WRITE ? cmd_data[0] : 1'b1;
								nb_reg   <= 4'd8;
								one_reg  <= 1'b0;
							end
							OP_BIT: begin
								st_reg   <= H_BITS;
								sh_reg   <= 8'hff;
								mbit_reg <= cmd_data[0];
								nb_reg   <= 4'd1;
								one_reg  <= 1'b1;
							end
							OP_PROG: begin
								st_reg <= H_PROG;
								pv_reg <= 1'b1;
							end
							default: st_reg <= H_IDLE;
						endcase
					end
				end
				H_RESET: begin
					tmr_reg <= tmr_reg + 16'd1;
					if (link.presence) begin
						pres_reg <= 1'b1;
					end
					if (tmr_reg == 16'(RESET_CYC - 1)) begin
						st_reg <= H_IDLE;
						rv_reg <= 1'b1;
						rd_reg <= {7'd0, pres_reg | link.presence};
					end
				end
				H_BITS: begin
					// Slot rate comes from this divider
					tmr_reg <= tmr_reg + 16'd1;
					if (tmr_reg == 16'(SLOT_CYC - 1)) begin
						tmr_reg  <= 16'h0000;
						slot_reg <= 1'b1;
					end
					if (slot_reg) begin
						sh_reg   <= {link.line, sh_reg[7:1]}; // see R10
						mbit_reg <= sh_reg[1];
						nb_reg   <= nb_reg - 4'd1;
						if (nb_reg == 4'd1) begin
							st_reg   <= H_IDLE;
							mbit_reg <= 1'b1;
							rv_reg   <= 1'b1;
							rd_reg   <= one_reg ? {7'd0, link.line}
								: {link.line, sh_reg[7:1]};
						end
					end
				end
				H_PROG: begin
					tmr_reg <= tmr_reg + 16'd1;
					if (tmr_reg == 16'(PROG_CYC - 1)) begin
						st_reg <= H_IDLE;
						pv_reg <= 1'b0;
						rv_reg <= 1'b1;
						rd_reg <= 8'h00;
					end
				end
			endcase
		end
	end

	// A slot landing with a clear is kept, not lost
	always_ff @(posedge clk) begin
		if (srst) begin
			crc_reg <= CRC_INIT; // see R4
		end else if (crc_clear) begin
			crc_reg <= slot_reg ? ricg_crc_bit(CRC_INIT, link.line) : CRC_INIT;
		end else if (slot_reg) begin
			crc_reg <= ricg_crc_bit(crc_reg, link.line); // see R3, R5, R15
		end
	end

endmodule // ricg_host

// ===== hw/ricg_if.sv
// Logic-level single-wire link between master and device.
// The shared line is wired-AND of both drivers; both sample on slot.
`timescale 1ns/1ps
interface ricg_if;
	logic bus_reset;
	logic slot;
	logic m_bit;
	logic prog_v;
	logic d_bit;
	logic presence;
	logic line;

	// Either end pulls the line low
	assign line = m_bit & d_bit;

	modport dev (
		input  bus_reset,
		input  slot,
		input  prog_v,
		input  line,
		output d_bit,
		output presence
	);

	modport host (
		output bus_reset,
		output slot,
		output m_bit,
		output prog_v,
		input  line,
		input  presence
	);
endinterface

// ===== hw/ricg_pkg.sv
// Shared constants, command codes, operation codes and check-value helpers
// for both ends of the identity link. Assumes one 200 MHz clock domain.
package ricg_pkg;

	localparam int          CLK_MHZ      = 200;
	localparam int          ID_BITS      = 64;
	localparam int          FAMILY_BITS  = 8;
	localparam int          SERIAL_BITS  = 48;
	localparam int          BODY_BITS    = FAMILY_BITS + SERIAL_BITS;
	localparam int          DATA_BYTES   = 128;
	localparam int          STAT_BYTES   = 8;
	localparam int          DATA_AW      = 7;
	localparam int          STAT_AW      = 3;
	localparam int          WP_BYTE      = 0;
	localparam int          PAGE_LSB     = 5;
	localparam logic [7:0]  ERASED       = 8'hff;
	localparam logic [7:0]  CRC_INIT     = 8'h00;
	localparam logic [7:0]  CRC_TAPS     = 8'h8c;

	// Identity-stage commands
	localparam logic [7:0]  CMD_READ_ID   = 8'h33;
	localparam logic [7:0]  CMD_MATCH_ID  = 8'h55;
	localparam logic [7:0]  CMD_SEARCH_ID = 8'hf0;
	localparam logic [7:0]  CMD_SKIP_ID   = 8'hcc;

	// Memory-stage commands
	localparam logic [7:0]  CMD_READ_MEM  = 8'hf0;
	localparam logic [7:0]  CMD_READ_CRC  = 8'hc3;
	localparam logic [7:0]  CMD_READ_STAT = 8'haa;
	localparam logic [7:0]  CMD_WRITE_MEM = 8'h0f;
	localparam logic [7:0]  CMD_WRITE_STAT = 8'h55;

	// Master timing in clock cycles
	localparam int          SLOT_CYC     = 16;
	localparam int          RESET_CYC    = 8;
	localparam int          PROG_CYC     = 16;

	typedef enum logic [2:0] {
		OP_RESET,
		OP_WRITE,
		OP_READ,
		OP_BIT,
		OP_PROG
	} ricg_op_t;

	// One step of the right-shifting accumulator
	function automatic logic [7:0] ricg_crc_bit(input logic [7:0] c,
		input logic b);
		logic [7:0] s;
		s = {1'b0, c[7:1]};
		if (c[0] ^ b) begin
			s = s ^ CRC_TAPS;
		end
		return s;
	endfunction

	function automatic logic [7:0] ricg_crc_byte(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] s;
		s = c;
		for (int i = 0; i < 8; i++) begin
			s = ricg_crc_bit(s, d[i]);
		end
		return s;
	endfunction

	function automatic logic [7:0] ricg_crc_body(
		input logic [BODY_BITS-1:0] body);
		logic [7:0] s;
		s = CRC_INIT;
		for (int i = 0; i < BODY_BITS; i++) begin
			s = ricg_crc_bit(s, body[i]);
		end
		return s;
	endfunction

endpackage

// ===== tb/ricg_chk_sva.sv
// Checker for the wires between the two link ends.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/1ps
module ricg_chk #(
	parameter int SLOT_CYC = 16,
	parameter int PROG_CYC = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link wires
	input wire logic bus_reset,
	input wire logic slot,
	input wire logic m_bit,
	input wire logic prog_v,
	input wire logic d_bit,
	input wire logic presence,
	input wire logic line
);
	logic [7:0] gap_reg;
	logic [7:0] pv_cnt_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Saturates so a long idle gap never wraps to a small value
	always_ff @(posedge clk) begin
		if (srst) begin
			gap_reg <= 8'hff;
		end else if (slot) begin
			gap_reg <= 8'h00;
		end else if (gap_reg != 8'hff) begin
			gap_reg <= gap_reg + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || !prog_v) begin
			pv_cnt_reg <= 8'h00;
		end else begin
			pv_cnt_reg <= pv_cnt_reg + 8'h01;
		end
	end

	presence_after_reset_a:
		assert property (presence |-> $past(bus_reset))
		else $error("presence pulse without a bus reset");
	presence_pulse_a:
		assert property (presence |=> !presence)
		else $error("presence longer than one cycle");
	reset_alone_a:
		assert property (bus_reset |-> (!slot && !prog_v) ##1 !bus_reset)
		else $error("bus reset overlaps traffic or lasts too long");
	slot_spacing_a:
		assert property (slot |-> gap_reg >= SLOT_CYC - 1)
		else $error("bit slots too close together");
	bit_stable_a:
		assert property (slot |-> $stable(m_bit))
		else $error("master bit changed at its slot");
	prog_len_a:
		assert property ($fell(prog_v) |-> pv_cnt_reg == PROG_CYC)
		else $error("programming pulse has wrong length");
	prog_quiet_a:
		assert property (prog_v |-> !slot && m_bit && line == d_bit)
		else $error("bit traffic during programming");
	release_after_reset_a:
		assert property (bus_reset |-> ##2 d_bit)
		else $error("device holds the line after bus reset");
endmodule // ricg_chk

// ===== tb/tb_top.sv
// Bench joining host and device ends over the link.
// Assumes the package, interface and both ends compiled first.
`timescale 1ns/1ps
module tb_top;
	import ricg_pkg::*;
	localparam logic [7:0]  FAM = 8'h3c;            // Arbitrary value
	localparam logic [47:0] SER = 48'h0a1b_2c3d_4e5f; // Arbitrary value
	logic        clk;
	logic        srst;
	logic        cmd_valid;
	logic        cmd_ready;
	ricg_op_t    cmd_op;
	logic [7:0]  cmd_data;
	logic        rsp_valid;
	logic [7:0]  rsp_data;
	logic        presence;
	logic        crc_clear;
	logic [7:0]  crc_value;
	logic        crc_ok;
	logic        unlocked;
	logic        prog_flag;
	logic [63:0] id_code;
	logic [63:0] exp_id;
	logic [7:0]  r;
	logic [7:0]  t;
	logic [7:0]  rc [3];
	int          miscompares;
	int          n_checks;
	int          pcnt = 0;

	ricg_if link_if ();
	ricg_dev #(.FAMILY(FAM), .SERIAL(SER)) ricg_dev_inst (
		.clk      (clk),
		.srst     (srst),
		.link     (link_if),
		.unlocked (unlocked),
		.prog_flag(prog_flag),
		.id_code  (id_code)
	);
	ricg_host #(.SLOT_CYC(SLOT_CYC), .PROG_CYC(PROG_CYC)) ricg_host_inst (
		.clk      (clk),
		.srst     (srst),
		.link     (link_if),
		.cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready),
		.cmd_op   (cmd_op),
		.cmd_data (cmd_data),
		.rsp_valid(rsp_valid),
		.rsp_data (rsp_data),
		.presence (presence),
		.crc_clear(crc_clear),
		.crc_value(crc_value),
		.crc_ok   (crc_ok)
	);
	ricg_chk #(.SLOT_CYC(SLOT_CYC), .PROG_CYC(PROG_CYC)) ricg_chk_inst (
		.clk      (clk),
		.srst     (srst),
		.bus_reset(link_if.bus_reset),
		.slot     (link_if.slot),
		.m_bit    (link_if.m_bit),
		.prog_v   (link_if.prog_v),
		.d_bit    (link_if.d_bit),
		.presence (link_if.presence),
		.line     (link_if.line)
	);

	function automatic logic [7:0] cby(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] s;
		s = c;
		for (int i = 0; i < 8; i++) begin
			s = {1'b0, s[7:1]} ^ ((s[0] ^ d[i]) ? 8'h8c : 8'h00);
		end
		return s;
	endfunction

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// Holds the request until the edge that takes it, then waits bounded
	task automatic op(input ricg_op_t o, input logic [7:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 500) begin
			tick;
			n++;
		end
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_data = d;
		tick;
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 500) begin
			tick;
			n++;
		end
		chk(n < 500, 1'b1);
		r = rsp_data;
	endtask

	task automatic wr(input logic [7:0] d);
		op(OP_WRITE, d);
	endtask

	task automatic rd(input logic [7:0] e);
		op(OP_READ, 8'hff);
		chk(r, e);
	endtask

	// Skip the identity stage, then command and address, low byte first
	task automatic mem(input logic [7:0] cm, input logic [7:0] ad);
		op(OP_RESET, 8'h00);
		wr(CMD_SKIP_ID);
		wr(cm);
		wr(ad);
		wr(8'h00);
		t = cby(cby(cby(8'h00, cm), ad), 8'h00);
	endtask

	task automatic wp(input logic [7:0] d, input logic [7:0] e);
		wr(d);
		rd(cby(t, d));
		op(OP_PROG, 8'h00);
		rd(e);
	endtask

	initial begin
		clk = 1'b0;
		forever begin
			#2.5 clk = ~clk;
		end
	end

	always @(posedge clk) begin
		if (prog_flag === 1'b1) begin
			pcnt <= pcnt + 1;
		end
	end

	// Whole run is near 18000 cycles; over three times that means a hang
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		test_done;
	end

	initial begin
		srst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = OP_RESET;
		cmd_data = 8'h00;
		crc_clear = 1'b0;
		miscompares = 0;
		n_checks = 0;
		rc[0] = CMD_READ_MEM;
		rc[1] = CMD_READ_CRC;
		rc[2] = CMD_READ_STAT;
		repeat (16) @(posedge clk);
		#1;
		srst = 1'b0;
		exp_id = {8'h00, SER, FAM};
		t = 8'h00;
		for (int i = 0; i < 7; i++) begin
			t = cby(t, exp_id[8*i +: 8]);
		end
		exp_id[63:56] = t;
		chk(id_code, exp_id);
		$display("test identity done");

		op(OP_RESET, 8'h00);
		chk({r, presence}, 9'h003);
		chk(unlocked, 1'b0);
		wr(CMD_READ_ID);
		crc_clear = 1'b1;
		tick;
		crc_clear = 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(exp_id[8*i +: 8]);
		end
		chk({crc_ok, crc_value}, 9'h100);
		chk(unlocked, 1'b1);
		$display("test read id done");

		op(OP_RESET, 8'h00);
		wr(8'h00);
		wr(CMD_READ_MEM);
		wr(8'h00);
		wr(8'h00);
		rd(8'hff);
		chk(unlocked, 1'b0);
		for (int b = 0; b < 2; b++) begin
			op(OP_RESET, 8'h00);
			wr(CMD_MATCH_ID);
			for (int i = 0; i < 8; i++) begin
				wr(exp_id[8*i +: 8] ^ {7'b0, i == 3 && b == 1});
			end
			chk(unlocked, b == 0);
		end
		$display("test lock and match done");

		op(OP_RESET, 8'h00);
		wr(CMD_SEARCH_ID);
		for (int i = 0; i < 64; i++) begin
			op(OP_BIT, 8'h01);
			chk(r, exp_id[i]);
			op(OP_BIT, 8'h01);
			chk(r, !exp_id[i]);
			op(OP_BIT, {7'b0, exp_id[i]});
		end
		chk(unlocked, 1'b1);
		$display("test search done");

		for (int k = 0; k < 3; k++) begin
			mem(rc[k], k == 2 ? 8'h07 : 8'h7f);
			rd(t);
			rd(ERASED);
			rd(cby(8'h00, ERASED));
			rd(8'hff);
		end
		$display("test reads done");

		mem(CMD_WRITE_MEM, 8'h21);
		wp(8'h5c, 8'h5c);
		t = cby(cby(8'h00, 8'h22), 8'h00);
		wp(8'hf3, 8'hf3);
		chk(pcnt, 2 * PROG_CYC);
		mem(CMD_WRITE_MEM, 8'h21);
		wp(8'hf3, 8'h50);
		mem(CMD_WRITE_STAT, 8'h01);
		wp(8'hfe, 8'hfe);
		mem(CMD_WRITE_STAT, 8'h00);
		wp(8'hfd, 8'hfd);
		mem(CMD_WRITE_MEM, 8'h21);
		wp(8'h00, 8'h50);
		mem(CMD_READ_MEM, 8'h21);
		rd(t);
		rd(8'h50);
		rd(8'hf3);
		mem(CMD_READ_STAT, 8'h01);
		rd(t);
		rd(8'hfe);
		$display("test writes done");
		test_done;
	end
endmodule // tb_top
